// *** include/asr_pkg.sv ***
// Package: register map, field positions, reset values and counts for the serial block
package asr_pkg;
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_DATA = 3'h1;
  localparam logic [2:0] ADDR_CTRL1 = 3'h2;
  localparam logic [2:0] ADDR_CTRL2 = 3'h3;
  localparam logic [2:0] ADDR_BAUD = 3'h4;
  localparam logic [2:0] ADDR_TXFINE = 3'h5;
  localparam logic [2:0] ADDR_RXFINE = 3'h6;
  // Status bit positions
  localparam int ST_TXE = 7;
  localparam int ST_TC = 6;
  localparam int ST_RXF = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_NF = 2;
  localparam int ST_FE = 1;
  localparam int ST_PE = 0;
  // Control one bit positions
  localparam int C1_R8 = 7;
  localparam int C1_T8 = 6;
  localparam int C1_M = 4;
  localparam int C1_WAKE = 3;
  localparam int C1_PCE = 2;
  localparam int C1_PS = 1;
  localparam int C1_PIE = 0;
  // Control two bit positions
  localparam int C2_TE = 3;
  localparam int C2_RE = 2;
  localparam int C2_MUTE = 1;
  // Baud select fields
  localparam int BD_COARSE_LSB = 6;
  localparam int BD_TX_LSB = 3;
  localparam int BD_RX_LSB = 0;
  localparam logic [7:0] STATUS_RST = 8'hc0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] OVERSAMPLE = 4'hf;
  localparam logic [3:0] SAMP_A = 4'h7;
  localparam logic [3:0] SAMP_B = 4'h8;
  localparam logic [3:0] SAMP_C = 4'h9;
  localparam logic [3:0] START_LAST = 4'h6;
  localparam logic [3:0] BITS8 = 4'h8;
  localparam logic [3:0] BITS9 = 4'h9;
endpackage

// *** logic/asr_serial.sv ***
// Serial block: baud dividers, receiver with mute, parity, noise; transmitter
`timescale 1ns/1ps
// Behaviour
// - Missing stop bit or break sets the framing error.
// - Framing error still loads data and rises with the receive full flag.
// - Framing error clears on status read followed by data read.
// - Each direction's baud is clock over 16, coarse and power divisors.
// - Fine prescaler divides the per-16 output further by 1 to 255.
// - Fine prescaler acts only when its register is nonzero.
// - Mute sleeps receiver; no receive flags or interrupts meanwhile, except from the address mark frame that wakes it.
// - Mute ends on idle line or on address mark, by select bit.
// - Idle wake clears mute without setting the idle flag.
// - Address mark word clears mute, sets full flag, received normally.
// - Frame has start, 8 or 9 bits incl. optional parity, stop.
// - Address mark test uses the data word's top bit, not parity.
// - Parity over 7 or 8 low bits is even or odd per select.
// - Transmitter replaces data top bit by parity when enabled.
// - Receiver parity mismatch sets flag and interrupt when enabled.
// - Bits take majority of samples 8, 9, 10; disagreement flags noise.
// - Sampling phase realigns at every start edge.
// - Start noise if pre-edge samples not all one or 3, 5, 7 high.
// - Start noise also when sample 8, 9 or 10 is high.
// - Data shifts least significant bit first both ways.
// - Word select picks eight or nine data bits per frame.
module asr_serial (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_line,
  output logic tx_line,
  output logic irq
);
  logic [7:0] ctrl1_reg, ctrl2_reg, baud_reg;
  logic [7:0] tx_fine_divisor_reg, rx_fine_divisor_reg;
  logic [8:0] data_reg, tx_hold_reg;
  logic rx_full_flag, framing_error_flag, noise_flag, parity_error_flag;
  logic idle_flag, tx_empty_flag, tx_done_flag, armed_reg, ack_reg;
  logic nine_bit_word_select, parity_enable, parity_odd_select;
  logic rouse_by_address_mark, receiver_mute, parity_irq_enable;
  logic tx_en, rx_en;
  logic [31:0] rdata_next;
  logic acc, status_rd, data_rd, data_wr;
  logic [3:0] nbits;
  assign nine_bit_word_select = ctrl1_reg[asr_pkg::C1_M];
  assign parity_enable = ctrl1_reg[asr_pkg::C1_PCE];
  assign parity_odd_select = ctrl1_reg[asr_pkg::C1_PS];
  assign rouse_by_address_mark = ctrl1_reg[asr_pkg::C1_WAKE];
  assign parity_irq_enable = ctrl1_reg[asr_pkg::C1_PIE];
  assign receiver_mute = ctrl2_reg[asr_pkg::C2_MUTE];
  assign tx_en = ctrl2_reg[asr_pkg::C2_TE];
  assign rx_en = ctrl2_reg[asr_pkg::C2_RE];
  assign nbits = nine_bit_word_select ? asr_pkg::BITS9 : asr_pkg::BITS8;

  // Bus: one wait cycle, answer on the second edge
  assign acc = (avs_read | avs_write) & clk_en;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign status_rd = acc & ack_reg & avs_read &
                     (avs_address == asr_pkg::ADDR_STATUS);
  assign data_rd = acc & ack_reg & avs_read &
                   (avs_address == asr_pkg::ADDR_DATA);
  assign data_wr = acc & ack_reg & avs_write &
                   (avs_address == asr_pkg::ADDR_DATA);
  always_ff @(posedge ref_clk) begin
    if (rst)
      ack_reg <= 1'b0;
    else if (clk_en)
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      armed_reg <= 1'b0;
    else if (acc & ack_reg)
      armed_reg <= status_rd;
  end

  function automatic logic [3:0] coarse_of(input logic [1:0] f);
    unique case (f)
      2'h0: coarse_of = 4'h1;
      2'h1: coarse_of = 4'h3;
      2'h2: coarse_of = 4'h4;
      2'h3: coarse_of = 4'hd;
    endcase
  endfunction

  // Tick chain: coarse stage shared by both directions, then power of two and fine per direction
  logic [3:0] coarse_max;
  logic [3:0] coarse_cnt;
  logic coarse_tick;
  assign coarse_max = coarse_of(baud_reg[asr_pkg::BD_COARSE_LSB +: 2]) - 4'h1;
  always_ff @(posedge ref_clk) begin
    if (rst)
      coarse_cnt <= 4'h0;
    else if (clk_en)
      coarse_cnt <= (coarse_cnt >= coarse_max) ? 4'h0 : coarse_cnt + 4'h1;
  end
  assign coarse_tick = clk_en & (coarse_cnt >= coarse_max);

  logic [1:0] os_tick;
  genvar gd;
  generate
    for (gd = 0; gd < 2; gd++) begin : g_div
      logic [2:0] sel;
      logic [7:0] fine, pow_cnt, fine_cnt, pow_max, fine_max;
      logic pow_tick;
      // Direction 0 is receive, 1 is transmit
      assign sel = gd == 0 ? baud_reg[asr_pkg::BD_RX_LSB +: 3]
                           : baud_reg[asr_pkg::BD_TX_LSB +: 3];
      assign fine = gd == 0 ? rx_fine_divisor_reg : tx_fine_divisor_reg;
      assign pow_max = (8'h01 << sel) - 8'h01;
      assign fine_max = (fine == 8'h00) ? 8'h00 : fine - 8'h01;
      assign pow_tick = coarse_tick & (pow_cnt >= pow_max);
      always_ff @(posedge ref_clk) begin
        if (rst)
          pow_cnt <= 8'h00;
        else if (coarse_tick)
          pow_cnt <= (pow_cnt >= pow_max) ? 8'h00 : pow_cnt + 8'h01;
      end
      // The fine stage divides the power-of-two tick down to the 16x tick; each bit is 16 such ticks
      always_ff @(posedge ref_clk) begin
        if (rst)
          fine_cnt <= 8'h00;
        else if (pow_tick)
          fine_cnt <= (fine_cnt >= fine_max) ? 8'h00 : fine_cnt + 8'h01;
      end
      assign os_tick[gd] = pow_tick & (fine_cnt >= fine_max);
    end
  endgenerate

  // Receiver
  typedef enum logic [1:0] {
    ASR_RX_IDLE = 2'b00, ASR_RX_START = 2'b01,
    ASR_RX_DATA = 2'b10, ASR_RX_STOP = 2'b11
  } asr_rx_t;
  asr_rx_t rx_state_reg;
  logic [3:0] samp_cnt, bit_cnt, ones_cnt;
  logic [2:0] hist_reg, mid_reg;
  logic [8:0] shift_reg;
  logic noise_acc, rx_bit, mid_noise, pre_ok;
  logic rx_done, rx_fe, par_bad, addr_mark, idle_seen, mute_clr;
  logic rx_tick;
  assign rx_tick = os_tick[0] & rx_en;
  assign rx_bit = (mid_reg[0] & mid_reg[1]) | (mid_reg[1] & rx_line) |
                  (mid_reg[0] & rx_line);
  assign mid_noise = ~((mid_reg[0] == mid_reg[1]) & (mid_reg[1] == rx_line));
  assign pre_ok = &hist_reg;
  always_ff @(posedge ref_clk) begin
    if (rst)
      hist_reg <= 3'h7;
    else if (rx_tick)
      hist_reg <= {hist_reg[1:0], rx_line};
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_state_reg <= ASR_RX_IDLE;
      samp_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      shift_reg <= 9'h000;
      mid_reg <= 3'h0;
      noise_acc <= 1'b0;
      ones_cnt <= 4'h0;
    end else if (rx_tick) begin
      samp_cnt <= samp_cnt + 4'h1;
      if (samp_cnt == asr_pkg::SAMP_A || samp_cnt == asr_pkg::SAMP_B)
        mid_reg <= {mid_reg[1:0], rx_line};
      unique case (rx_state_reg)
        ASR_RX_IDLE: begin
          if (!rx_line) begin
            rx_state_reg <= ASR_RX_START;
            samp_cnt <= 4'h1;
            noise_acc <= noise_acc | ~pre_ok;
          end else if (samp_cnt == asr_pkg::OVERSAMPLE) begin
            ones_cnt <= (ones_cnt == 4'hf) ? ones_cnt : ones_cnt + 4'h1;
          end
        end
        ASR_RX_START: begin
          if ((samp_cnt == 4'h2 || samp_cnt == 4'h4 ||
               samp_cnt == asr_pkg::START_LAST) && rx_line)
            noise_acc <= 1'b1;
          if (samp_cnt == asr_pkg::SAMP_C) begin
            if (rx_bit) begin
              noise_acc <= 1'b1;
              rx_state_reg <= ASR_RX_IDLE;
              ones_cnt <= 4'h0;
            end else
              noise_acc <= noise_acc | mid_noise;
          end
          if (samp_cnt == asr_pkg::OVERSAMPLE) begin
            rx_state_reg <= ASR_RX_DATA;
            bit_cnt <= 4'h0;
          end
        end
        ASR_RX_DATA: begin
          if (samp_cnt == asr_pkg::SAMP_C) begin
            shift_reg <= {rx_bit, shift_reg[8:1]};
            noise_acc <= noise_acc | mid_noise;
          end
          if (samp_cnt == asr_pkg::OVERSAMPLE) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == nbits - 4'h1)
              rx_state_reg <= ASR_RX_STOP;
          end
        end
        ASR_RX_STOP: begin
          if (samp_cnt == asr_pkg::SAMP_C) begin
            rx_state_reg <= ASR_RX_IDLE;
            ones_cnt <= 4'h0;
            noise_acc <= 1'b0;
            samp_cnt <= 4'h0;
          end
        end
      endcase
    end
  end
  // Word aligned to bit 0 regardless of length
  logic [8:0] word;
  assign word = nine_bit_word_select ? shift_reg : {1'b0, shift_reg[8:1]};
  assign rx_done = rx_tick & (rx_state_reg == ASR_RX_STOP) &
                   (samp_cnt == asr_pkg::SAMP_C);
  assign rx_fe = ~rx_bit;
  assign par_bad = parity_enable &
                   ((^word) ^ parity_odd_select);
  // address mark uses the data word top bit
  // Parity sits in the top position, so the mark is the bit below it
  assign addr_mark = parity_enable ?
                     (nine_bit_word_select ? word[7] : word[6]) :
                     (nine_bit_word_select ? word[8] : word[7]);
  // Idle frame: start plus word plus stop of ones
  assign idle_seen = rx_tick & (rx_state_reg == ASR_RX_IDLE) &
                     (samp_cnt == asr_pkg::OVERSAMPLE) &
                     (ones_cnt == nbits + 4'h1);
  assign mute_clr = receiver_mute &
                    (rouse_by_address_mark ? (rx_done & addr_mark)
                                           : idle_seen);
  logic rx_load;
  // nothing set while muted unless the address mark wakes it
  assign rx_load = rx_done & (~receiver_mute | (rouse_by_address_mark &
                   addr_mark));

  // Receive status flags; set wins over the clear sequence
  logic seq_clear;
  assign seq_clear = data_rd & armed_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_full_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      noise_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      idle_flag <= 1'b0;
      data_reg <= 9'h000;
    end else if (clk_en) begin
      if (rx_load) begin
        // data moves in even on framing error
        data_reg <= word;
        rx_full_flag <= 1'b1;
        framing_error_flag <= rx_fe;
        noise_flag <= noise_acc | mid_noise;
        parity_error_flag <= par_bad;
      end else if (seq_clear) begin
        rx_full_flag <= 1'b0;
        framing_error_flag <= 1'b0;
        noise_flag <= 1'b0;
        parity_error_flag <= 1'b0;
        idle_flag <= 1'b0;
      end
      if (idle_seen & ~receiver_mute)
        idle_flag <= 1'b1;
    end
  end

  // Transmitter
  typedef enum logic [1:0] {
    ASR_TX_IDLE = 2'b00, ASR_TX_RUN = 2'b01
  } asr_tx_t;
  asr_tx_t tx_state_reg;
  logic [10:0] tx_shift_reg;
  logic [3:0] tx_samp, tx_bits;
  logic tx_tick, tx_par;
  logic [8:0] tx_word;
  assign tx_tick = os_tick[1] & tx_en;
  // parity replaces the data top bit
  assign tx_par = (nine_bit_word_select ? ^tx_hold_reg[7:0]
                                        : ^tx_hold_reg[6:0]) ^ parity_odd_select;
  always_comb begin
    tx_word = tx_hold_reg;
    if (!nine_bit_word_select)
      tx_word[8] = 1'b1;
    if (parity_enable) begin
      if (nine_bit_word_select)
        tx_word[8] = tx_par;
      else
        tx_word[7] = tx_par;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_state_reg <= ASR_TX_IDLE;
      tx_shift_reg <= 11'h7ff;
      tx_samp <= 4'h0;
      tx_bits <= 4'h0;
      tx_line <= 1'b1;
      tx_done_flag <= 1'b1;
    end else if (clk_en) begin
      if (data_wr & armed_reg)
        tx_done_flag <= 1'b0;
      if (tx_tick) begin
        tx_samp <= tx_samp + 4'h1;
        unique case (tx_state_reg)
          ASR_TX_IDLE: begin
            tx_line <= 1'b1;
            if (!tx_empty_flag && tx_samp == asr_pkg::OVERSAMPLE) begin
              tx_shift_reg <= {1'b1, tx_word, 1'b0};
              tx_bits <= nbits + 4'h1;
              tx_state_reg <= ASR_TX_RUN;
            end
          end
          ASR_TX_RUN: begin
            if (tx_samp == 4'h0)
              tx_line <= tx_shift_reg[0];
            if (tx_samp == asr_pkg::OVERSAMPLE) begin
              tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
              if (tx_bits == 4'h0) begin
                tx_state_reg <= ASR_TX_IDLE;
                tx_done_flag <= 1'b1;
              end else
                tx_bits <= tx_bits - 4'h1;
            end
          end
        endcase
      end
    end
  end
  logic tx_take;
  assign tx_take = tx_tick & (tx_state_reg == ASR_TX_IDLE) &
                   ~tx_empty_flag & (tx_samp == asr_pkg::OVERSAMPLE);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_empty_flag <= 1'b1;
      tx_hold_reg <= 9'h000;
    end else if (clk_en) begin
      if (data_wr) begin
        tx_hold_reg <= {ctrl1_reg[asr_pkg::C1_T8], avs_writedata[7:0]};
        tx_empty_flag <= 1'b0;
      end else if (tx_take)
        tx_empty_flag <= 1'b1;
    end
  end

  // Control registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl1_reg <= asr_pkg::CTRL_RST;
      ctrl2_reg <= asr_pkg::CTRL_RST;
      baud_reg <= asr_pkg::CTRL_RST;
      tx_fine_divisor_reg <= asr_pkg::CTRL_RST;
      rx_fine_divisor_reg <= asr_pkg::CTRL_RST;
    end else if (clk_en) begin
      if (acc & ack_reg & avs_write) begin
        unique case (avs_address)
          asr_pkg::ADDR_CTRL1: ctrl1_reg <= avs_writedata[7:0];
          asr_pkg::ADDR_CTRL2: ctrl2_reg <= avs_writedata[7:0];
          asr_pkg::ADDR_BAUD: baud_reg <= avs_writedata[7:0];
          asr_pkg::ADDR_TXFINE: tx_fine_divisor_reg <= avs_writedata[7:0];
          asr_pkg::ADDR_RXFINE: rx_fine_divisor_reg <= avs_writedata[7:0];
          default: ;
        endcase
      end
      // hardware clears mute; wins over write
      if (mute_clr)
        ctrl2_reg[asr_pkg::C2_MUTE] <= 1'b0;
      if (rx_load)
        ctrl1_reg[asr_pkg::C1_R8] <= word[8];
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (avs_address)
      asr_pkg::ADDR_STATUS:
        rdata_next[7:0] = {tx_empty_flag, tx_done_flag, rx_full_flag,
                           idle_flag, 1'b0, noise_flag,
                           framing_error_flag, parity_error_flag};
      asr_pkg::ADDR_DATA: rdata_next[7:0] = data_reg[7:0];
      asr_pkg::ADDR_CTRL1: rdata_next[7:0] = ctrl1_reg;
      asr_pkg::ADDR_CTRL2: rdata_next[7:0] = ctrl2_reg;
      asr_pkg::ADDR_BAUD: rdata_next[7:0] = baud_reg;
      asr_pkg::ADDR_TXFINE: rdata_next[7:0] = tx_fine_divisor_reg;
      asr_pkg::ADDR_RXFINE: rdata_next[7:0] = rx_fine_divisor_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (clk_en)
      avs_readdata <= rdata_next;
  end

  // parity interrupt; while muted, flags set only by the address mark frame that wakes it
  assign irq = parity_error_flag & parity_irq_enable;
endmodule // asr_serial

// *** tb/asr_checker.sv ***
// Checker: port-level assertions for the serial block
`timescale 1ns/1ps
module asr_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rx_line,
  input wire logic tx_line,
  input wire logic irq
);
  logic acc;
  logic st_rd;
  logic armed_reg;
  logic tx_last_reg;
  logic [4:0] run_reg;
  assign acc = (avs_read || avs_write) && !avs_waitrequest && clk_en;
  assign st_rd = acc && avs_read && avs_address == asr_pkg::ADDR_STATUS;
  // Status read arms the flag clear
  always_ff @(posedge ref_clk) begin
    if (rst) armed_reg <= 1'b0;
    else if (acc) armed_reg <= st_rd;
  end
  // Cycles the serial output has held its level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_reg <= 5'h00;
      tx_last_reg <= 1'b1;
    end else begin
      tx_last_reg <= tx_line;
      if (tx_line != tx_last_reg) run_reg <= 5'h00;
      else if (run_reg != 5'h1f) run_reg <= run_reg + 5'h01;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_wait_first: assert property (
    ($rose(avs_read) || $rose(avs_write)) && clk_en
      |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("waitrequest not one cycle");
  a_irq_reset: assert property ($fell(rst) |-> !irq)
    else $error("irq high after reset");
  a_tx_bit_min: assert property (
    tx_line != tx_last_reg |-> run_reg >= 5'h0f)
    else $error("serial bit shorter than 16 cycles");
  a_start_low: assert property ($fell(tx_line) |-> (!tx_line)[*8])
    else $error("start bit cut short");
  a_frozen_state: assert property (
    !clk_en |=> $stable(tx_line) && $stable(avs_readdata) && $stable(irq))
    else $error("state moved while clock enable low");
  a_fe_with_full: assert property (
    st_rd && avs_readdata[asr_pkg::ST_FE] |-> avs_readdata[asr_pkg::ST_RXF])
    else $error("framing error without receive full");
  a_nf_with_full: assert property (
    st_rd && avs_readdata[asr_pkg::ST_NF] |-> avs_readdata[asr_pkg::ST_RXF])
    else $error("noise without receive full");
  a_irq_cleared: assert property (
    acc && avs_read && avs_address == asr_pkg::ADDR_DATA && armed_reg
      |=> !irq)
    else $error("parity irq survives clear sequence");
  c_fe_seen: cover property (st_rd && avs_readdata[asr_pkg::ST_FE]);
  c_irq_rose: cover property ($rose(irq));
  c_freeze: cover property (!clk_en ##1 clk_en);
endmodule // asr_checker
bind asr_serial asr_checker chk_u (.ref_clk(ref_clk), .rst(rst),
  .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .rx_line(rx_line), .tx_line(tx_line), .irq(irq));

// *** tb/asr_peer.sv ***
// Peer node: sends frames to the receiver and captures transmitted frames
`timescale 1ns/1ps
module asr_peer (
  input wire logic ref_clk,
  output logic rx_line,
  input wire logic tx_line
);
  int tbit = 32;
  int nbits = 8;
  int cyc = 0;
  int c0 = 0;
  int edge_bad = 0;
  logic busy = 1'b0;
  logic [8:0] w;
  logic [9:0] rxq[$];
  initial rx_line = 1'b1;
  always @(posedge ref_clk) cyc <= cyc + 1;
  task automatic send(input logic [8:0] d, input int nb, input logic stp,
                      input int nbit, input int bt);
    int s;
    s = bt / 16;
    @(posedge ref_clk);
    rx_line <= 1'b0;
    repeat (bt) @(posedge ref_clk);
    for (int i = 0; i < nb; i++) begin
      rx_line <= d[i];
      if (i == nbit) begin
        repeat (8 * s + s / 2) @(posedge ref_clk);
        rx_line <= ~d[i];
        repeat (s) @(posedge ref_clk);
        rx_line <= d[i];
        repeat (bt - 9 * s - s / 2) @(posedge ref_clk);
      end else repeat (bt) @(posedge ref_clk);
    end
    rx_line <= stp;
    repeat (bt) @(posedge ref_clk);
    rx_line <= 1'b1;
    repeat (bt) @(posedge ref_clk);
  endtask
  always begin
    @(negedge tx_line);
    c0 = cyc;
    busy = 1'b1;
    w = 9'h000;
    repeat (tbit / 2) @(posedge ref_clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (tbit) @(posedge ref_clk);
      w[i] = tx_line;
    end
    repeat (tbit) @(posedge ref_clk);
    rxq.push_back({tx_line, w});
    busy = 1'b0;
  end
  // edges fall on whole bit times
  always @(tx_line) if (busy && (cyc - c0) % tbit != 0) edge_bad++;
endmodule // asr_peer

// *** tb/testbench.sv ***
// Testbench: register traffic, serial frames both ways, mute and freeze
`timescale 1ns/1ps
module testbench;
  logic ref_clk, rst, clk_en, avs_read, avs_write, tx_line, rx_line, irq;
  logic avs_waitrequest;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0] q;
  logic [8:0] w;
  int fails, n_compared, cyc, rbit, t;
  int cotab[4] = '{1, 3, 4, 13};
  // m pce ps coarse txp rxp txf rxf stop perr noisebit
  int cfg[6][11] = '{'{0, 0, 0, 0, 1, 0, 0, 2, 1, 0, -1},
    '{0, 1, 0, 1, 0, 0, 0, 0, 1, 1, -1}, '{1, 1, 1, 2, 0, 1, 3, 0, 1, 0, -1},
    '{1, 0, 0, 3, 0, 0, 0, 1, 0, 0, -1}, '{0, 0, 0, 0, 2, 0, 0, 3, 1, 0, 3},
    '{0, 1, 1, 0, 0, 0, 0, 0, 1, 0, -1}};
  asr_serial dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_line(rx_line),
    .tx_line(tx_line), .irq(irq));
  asr_peer peer_u (.ref_clk(ref_clk), .rx_line(rx_line), .tx_line(tx_line));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp,
                     input string msg);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata[7:0];
    chk(10'(n < 40), 10'h001, "bus answer");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic par(input logic [8:0] v, input int n,
                               input logic odd);
    par = odd;
    for (int i = 0; i < n; i++) par ^= v[i];
  endfunction
  task automatic wait_rx();
    int n;
    n = 0;
    do begin
      bus(1'b0, asr_pkg::ADDR_STATUS, 8'h00);
      n++;
    end while (q[asr_pkg::ST_RXF] !== 1'b1 && n < 3000);
  endtask
  task automatic run_case(input int i);
    int nb, tb;
    logic [8:0] e;
    nb = cfg[i][0] ? 9 : 8;
    tb = 16 * cotab[cfg[i][3]] * (1 << cfg[i][4]) * (cfg[i][6] ? cfg[i][6] : 1);
    rbit = 16 * cotab[cfg[i][3]] * (1 << cfg[i][5]) * (cfg[i][7] ? cfg[i][7] : 1);
    bus(1'b1, asr_pkg::ADDR_CTRL2, 8'h00);
    bus(1'b1, asr_pkg::ADDR_BAUD, 8'(cfg[i][3] * 64 + cfg[i][4] * 8 + cfg[i][5]));
    bus(1'b1, asr_pkg::ADDR_TXFINE, 8'(cfg[i][6]));
    bus(1'b1, asr_pkg::ADDR_RXFINE, 8'(cfg[i][7]));
    w = 9'($urandom);
    bus(1'b1, asr_pkg::ADDR_CTRL1, {1'b0, w[8], 1'b0, 1'(cfg[i][0]), 1'b0,
      1'(cfg[i][1]), 1'(cfg[i][2]), 1'(cfg[i][9])});
    peer_u.tbit = tb;
    peer_u.nbits = nb;
    bus(1'b1, asr_pkg::ADDR_CTRL2, 8'h0c);
    bus(1'b0, asr_pkg::ADDR_STATUS, 8'h00);
    bus(1'b1, asr_pkg::ADDR_DATA, w[7:0]);
    e = nb == 9 ? w : {1'b0, w[7:0]};
    if (cfg[i][1] != 0) e[nb - 1] = par(e, nb - 1, 1'(cfg[i][2]));
    for (t = 0; t < 6000 && peer_u.rxq.size() == 0; t++) @(posedge ref_clk);
    chk(peer_u.rxq.size() ? peer_u.rxq.pop_front() : 10'h000, {1'b1, e}, "tx");
    chk(10'(peer_u.edge_bad), 10'h000, "tx bit time");
    w = 9'($urandom);
    if (nb == 8) w[8] = 1'b0;
    if (cfg[i][1] != 0) w[nb - 1] = par(w, nb - 1, 1'(cfg[i][2])) ^ 1'(cfg[i][9]);
    peer_u.send(w, nb, 1'(cfg[i][8]), cfg[i][10], rbit);
    wait_rx();
    chk(10'({q[asr_pkg::ST_RXF], q[2:0]}), 10'({1'b1, cfg[i][10] >= 0,
      cfg[i][8] == 0, 1'(cfg[i][9])}), "rx flags");
    chk(10'(irq), 10'(cfg[i][9]), "parity irq");
    bus(1'b0, asr_pkg::ADDR_DATA, 8'h00);
    chk(10'(q), 10'(w[7:0]), "rx data");
    bus(1'b0, asr_pkg::ADDR_CTRL1, 8'h00);
    if (nb == 9) chk(10'(q[asr_pkg::C1_R8]), 10'(w[8]), "ninth bit");
    bus(1'b0, asr_pkg::ADDR_STATUS, 8'h00);
    chk(10'(q & 8'h27), 10'h000, "flags cleared");
  endtask
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 3'h0;
    avs_writedata = 32'h00000000;
    fails = 0;
    n_compared = 0;
    cyc = 0;
    void'($urandom(81));
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b1, asr_pkg::ADDR_STATUS, 8'h00);
    bus(1'b0, asr_pkg::ADDR_STATUS, 8'h00);
    chk(10'(q), 10'(asr_pkg::STATUS_RST), "status after reset");
    bus(1'b1, 3'h7, 8'hff);
    bus(1'b0, 3'h7, 8'h00);
    chk(10'(q), 10'h000, "unmapped");
    for (int i = 0; i < 6; i++) run_case(i);
    bus(1'b1, asr_pkg::ADDR_CTRL1, 8'h0e);
    bus(1'b1, asr_pkg::ADDR_CTRL2, 8'h0e);
    w = 9'($urandom) & 9'h03f;
    if (!par(w, 7, 1'b1)) w[0] = ~w[0];
    w[7] = 1'b1;
    peer_u.send(w, 8, 1'b1, -1, rbit);
    bus(1'b0, asr_pkg::ADDR_STATUS, 8'h00);
    chk(10'(q[asr_pkg::ST_RXF]), 10'h000, "muted frame");
    bus(1'b0, asr_pkg::ADDR_CTRL2, 8'h00);
    chk(10'(q[asr_pkg::C2_MUTE]), 10'h001, "still muted");
    w = (9'($urandom) & 9'h07f) | 9'h040;
    w[7] = par(w, 7, 1'b1);
    peer_u.send(w, 8, 1'b1, -1, rbit);
    wait_rx();
    bus(1'b0, asr_pkg::ADDR_CTRL2, 8'h00);
    chk(10'(q[asr_pkg::C2_MUTE]), 10'h000, "address wake");
    bus(1'b0, asr_pkg::ADDR_DATA, 8'h00);
    chk(10'(q), 10'(w[7:0]), "address word");
    bus(1'b1, asr_pkg::ADDR_CTRL1, 8'h06);
    bus(1'b1, asr_pkg::ADDR_CTRL2, 8'h0e);
    t = 0;
    do begin
      bus(1'b0, asr_pkg::ADDR_CTRL2, 8'h00);
      t++;
    end while (q[asr_pkg::C2_MUTE] !== 1'b0 && t < 200);
    chk(10'(q[asr_pkg::C2_MUTE]), 10'h000, "idle wake");
    bus(1'b0, asr_pkg::ADDR_STATUS, 8'h00);
    chk(10'(q[asr_pkg::ST_IDLE]), 10'h000, "no idle flag");
    clk_en <= 1'b0;
    repeat ($urandom_range(18, 3)) @(posedge ref_clk);
    clk_en <= 1'b1;
    bus(1'b0, asr_pkg::ADDR_STATUS, 8'h00);
    chk(10'(q[asr_pkg::ST_TXE]), 10'h001, "after freeze");
    finish_test();
  end
endmodule // testbench
